// *** test/pmoc_host_model.sv ***
// bus host model driving the decoded command port
// assumes the block's clock; drives at falling edges
`timescale 1ns/1ps
module pmoc_host_model (
    // clock
    input wire clk,
    // command request
    output logic cmd_valid = 1'b0,
    output logic cmd_write = 1'b0,
    output logic cmd_has_data = 1'b0,
    output logic [7:0] cmd_code = 8'h00,
    output logic [7:0] cmd_wdata = 8'h00,
    // command answer
    input wire rsp_valid_q,
    input wire [7:0] rsp_rdata_q,
    input wire cmd_reject_q
);
    logic last_rej;
    logic [7:0] dummy;
    // ----------
    // transfers
    // ----------
    // released code and data turn inverted so a stale value never looks valid
    task xfer(input logic w, d, input logic [7:0] c, v, output logic [7:0] r);
        begin
            @(negedge clk);
            cmd_valid = 1'b1;
            cmd_write = w;
            cmd_has_data = d;
            cmd_code = c;
            cmd_wdata = v;
            @(negedge clk);
            // answers stand only in the cycle after the taking edge
            r = rsp_valid_q ? rsp_rdata_q : 8'hEE;
            last_rej = cmd_reject_q;
            cmd_valid = 1'b0;
            cmd_code = ~c;
            cmd_wdata = ~v;
        end
    endtask
    task wr(input logic [7:0] c, v);
        xfer(1'b1, 1'b1, c, v, dummy);
    endtask
    task rd(input logic [7:0] c, output logic [7:0] r);
        xfer(1'b0, 1'b0, c, 8'h00, r);
    endtask
    // data byte only when a refusal is wanted
    task clr(input logic d);
        xfer(1'b1, d, 8'h03, 8'h00, dummy);
    endtask
endmodule

// *** test/pmoc_onoff_chk_assertions.sv ***
// assertions for the output on/off command-register block
// assumes binding onto pmoc_onoff_ctrl, one clock domain
`timescale 1ns/1ps
module pmoc_onoff_chk #(
    parameter FAULT_W = 4
) (
    // clock and reset
    input wire clk,
    input wire rstn,
    // command port
    input wire cmd_valid,
    input wire cmd_write,
    input wire cmd_has_data,
    input wire [7:0] cmd_code,
    input wire rsp_valid_q,
    input wire [7:0] rsp_rdata_q,
    input wire cmd_reject_q,
    // conditions
    input wire vin_above_uvlo,
    input wire [FAULT_W-1:0] fault_cond,
    input wire input_current_warn_hit,
    // block outputs
    input wire power_up_done_q,
    input wire output_enable_q,
    input wire latched_off_q,
    input wire regulator_hot_alarm_q,
    input wire [FAULT_W:0] fault_status,
    input wire alert_output
);
    // ----------
    // decode
    // ----------
    wire rd_op = cmd_valid && !cmd_write && cmd_code == 8'h01;
    wire rd_cfg = cmd_valid && !cmd_write && cmd_code == 8'h02;
    wire clr = cmd_valid && cmd_write && !cmd_has_data && cmd_code == 8'h03;
    wire clr_dat = cmd_valid && cmd_write && cmd_has_data && cmd_code == 8'h03;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // ----------
    // properties
    // ----------
    property p_rd_op; rd_op |=> rsp_valid_q && !rsp_rdata_q[6]; endproperty
    a_rd_op: assert property (p_rd_op) else $error("soft-off bit not zero");
    property p_rd_cfg; rd_cfg |=> rsp_valid_q && rsp_rdata_q[7:4] == 4'h1
        && rsp_rdata_q[1:0] == 2'h3; endproperty
    a_rd_cfg: assert property (p_rd_cfg) else $error("fixed bits wrong");
    property p_rej; clr_dat |=> cmd_reject_q; endproperty
    a_rej: assert property (p_rej) else $error("clear with data taken");
    property p_hot; regulator_hot_alarm_q |-> $past(input_current_warn_hit); endproperty
    a_hot: assert property (p_hot) else $error("alarm without warning");
    property p_clr; clr && !(|fault_cond) && !input_current_warn_hit
        |=> !(|fault_status) && !alert_output; endproperty
    a_clr: assert property (p_clr) else $error("status not cleared");
    property p_again; clr && fault_cond[0] ##1 fault_cond[0]
        |=> fault_status[0] && alert_output; endproperty
    a_again: assert property (p_again) else $error("standing fault not set again");
    property p_latch; latched_off_q |=> !output_enable_q; endproperty
    a_latch: assert property (p_latch) else $error("latched unit enabled");
    property p_keep; clr && latched_off_q |=> latched_off_q; endproperty
    a_keep: assert property (p_keep) else $error("clear restarted unit");
    property p_off; $fell(vin_above_uvlo) |-> ##[1:4] !output_enable_q; endproperty
    a_off: assert property (p_off) else $error("slow turn-off");
    property p_on; $rose(output_enable_q) |-> $past(vin_above_uvlo, 3)
        && power_up_done_q; endproperty
    a_on: assert property (p_on) else $error("enabled without input");
endmodule
bind pmoc_onoff_ctrl pmoc_onoff_chk #(.FAULT_W(FAULT_W)) u_chk (
    .clk(clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_has_data(cmd_has_data), .cmd_code(cmd_code), .rsp_valid_q(rsp_valid_q),
    .rsp_rdata_q(rsp_rdata_q), .cmd_reject_q(cmd_reject_q),
    .vin_above_uvlo(vin_above_uvlo), .fault_cond(fault_cond),
    .input_current_warn_hit(input_current_warn_hit), .power_up_done_q(power_up_done_q),
    .output_enable_q(output_enable_q), .latched_off_q(latched_off_q),
    .regulator_hot_alarm_q(regulator_hot_alarm_q), .fault_status(fault_status),
    .alert_output(alert_output));

// *** test/tb.sv ***
// self-checking bench for the output on/off command-register block
// assumes the host model and the bound checker are compiled first
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("ERROR %0t: got %h want %h", $time, g, e); end end
module tb;
    localparam [6:0] ABASE = 7'h50;
    localparam [7:0] NOM = 8'h40;
    localparam [7:0] LOW = 8'h30;
    localparam [7:0] HIGH = 8'h50;
    logic clk, rstn, enable_pin, vin_above_uvlo, strap_mode, strap_cmd_gate;
    logic strap_pin_control_gate, input_current_warn_hit;
    logic [1:0] strap_hot_on_iin;
    logic [3:0] address_select_pin, fault_cond;
    logic [7:0] rdv;
    wire cmd_valid, cmd_write, cmd_has_data, rsp_valid_q, cmd_reject_q, power_up_done_q;
    wire output_enable_q, latched_off_q, margin_act_on_fault_q, regulator_hot_alarm_q;
    wire alert_output;
    wire [7:0] cmd_code, cmd_wdata, rsp_rdata_q, vout_target_q;
    wire [6:0] slave_addr_q;
    wire [4:0] fault_status;
    int error_cnt = 0;
    int samples_checked = 0;
    pmoc_host_model host (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_has_data(cmd_has_data), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
        .rsp_valid_q(rsp_valid_q), .rsp_rdata_q(rsp_rdata_q), .cmd_reject_q(cmd_reject_q));
    pmoc_onoff_ctrl #(.ADDR_BASE(ABASE)) uut (.clk(clk), .rstn(rstn),
        .address_select_pin(address_select_pin), .enable_pin(enable_pin),
        .vin_above_uvlo(vin_above_uvlo), .strap_mode(strap_mode),
        .strap_cmd_gate(strap_cmd_gate), .strap_pin_control_gate(strap_pin_control_gate),
        .strap_hot_on_iin(strap_hot_on_iin), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_has_data(cmd_has_data), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
        .rsp_valid_q(rsp_valid_q), .rsp_rdata_q(rsp_rdata_q), .cmd_reject_q(cmd_reject_q),
        .fault_cond(fault_cond), .input_current_warn_hit(input_current_warn_hit),
        .vout_nominal(NOM), .margin_low_level(LOW), .margin_high_level(HIGH),
        .slave_addr_q(slave_addr_q), .power_up_done_q(power_up_done_q),
        .output_enable_q(output_enable_q), .latched_off_q(latched_off_q),
        .vout_target_q(vout_target_q), .margin_act_on_fault_q(margin_act_on_fault_q),
        .regulator_hot_alarm_q(regulator_hot_alarm_q), .fault_status(fault_status),
        .alert_output(alert_output));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ----------
    // tests
    // ----------
    // a write during power-up must be refused, not queued
    task do_reset;
        begin
            @(negedge clk);
            rstn = 1'b0;
            repeat (4) @(negedge clk);
            rstn = 1'b1;
            host.wr(8'h02, 8'h08);
            `CHK(host.last_rej, 1'b1)
            for (int i = 0; i < 20 && power_up_done_q !== 1'b1; i++) @(negedge clk);
            `CHK(power_up_done_q, 1'b1)
        end
    endtask
    task t_regs;
        begin
            `CHK(slave_addr_q, {ABASE[6:4], 4'hA})
            host.rd(8'h01, rdv);
            `CHK(rdv, 8'h00)
            host.rd(8'h02, rdv);
            `CHK(rdv, 8'h17)
            host.wr(8'h01, 8'hFF);
            host.rd(8'h01, rdv);
            `CHK(rdv, 8'hBF)
            host.wr(8'h02, 8'hFF);
            host.rd(8'h02, rdv);
            `CHK(rdv, 8'h1F)
            host.wr(8'h02, 8'h00);
            host.rd(8'h02, rdv);
            `CHK(rdv, 8'h13)
            host.rd(8'h03, rdv);
            `CHK(host.last_rej, 1'b1)
            host.clr(1'b1);
            `CHK(host.last_rej, 1'b1)
            $display("regs test done");
        end
    endtask
    task t_strap;
        begin
            @(negedge clk);
            strap_mode = 1'b1;
            address_select_pin = 4'h3;
            do_reset;
            `CHK(slave_addr_q, {ABASE[6:4], 4'h3})
            host.rd(8'h02, rdv);
            `CHK(rdv, 8'h1F)
            host.rd(8'h01, rdv);
            `CHK(rdv, 8'h01)
            host.wr(8'h02, 8'h04);
            host.rd(8'h02, rdv);
            `CHK(rdv, 8'h17)
            $display("strap test done");
        end
    endtask
    task t_onoff;
        logic [3:0] b;
        begin
            host.wr(8'h01, 8'h80);
            for (int i = 0; i < 16; i++) begin
                b = i[3:0];
                host.wr(8'h02, {4'h0, b[3], b[2], 2'b00});
                @(negedge clk);
                enable_pin = b[1];
                vin_above_uvlo = b[0];
                repeat (5) @(negedge clk);
                `CHK(output_enable_q, b[0] & b[3] & (!b[2] | b[1]))
            end
            host.wr(8'h01, 8'h00);
            repeat (3) @(negedge clk);
            `CHK(output_enable_q, 1'b0)
            $display("onoff test done");
        end
    endtask
    task t_margin;
        logic [7:0] e;
        begin
            for (int i = 0; i < 16; i++) begin
                host.wr(8'h01, {2'b00, i[3:0], 2'b00});
                repeat (2) @(negedge clk);
                e = (i == 5 || i == 6) ? LOW : ((i == 9 || i == 10) ? HIGH : NOM);
                `CHK(vout_target_q, e)
                `CHK(margin_act_on_fault_q, i == 6 || i == 10)
            end
            $display("margin test done");
        end
    endtask
    task t_hot;
        begin
            for (int i = 0; i < 4; i++) begin
                host.wr(8'h01, {6'h00, i[1:0]});
                @(negedge clk);
                input_current_warn_hit = 1'b1;
                repeat (3) @(negedge clk);
                `CHK(regulator_hot_alarm_q, i == 1)
                input_current_warn_hit = 1'b0;
                repeat (3) @(negedge clk);
            end
            $display("hot test done");
        end
    endtask
    task t_clear;
        begin
            host.clr(1'b0);
            @(negedge clk);
            `CHK(fault_status, 5'h00)
            fault_cond = 4'h1;
            @(negedge clk);
            fault_cond = 4'h0;
            repeat (2) @(negedge clk);
            `CHK(alert_output, 1'b1)
            host.clr(1'b0);
            @(negedge clk);
            `CHK({fault_status, alert_output}, 6'h00)
            fault_cond = 4'h1;
            host.clr(1'b0);
            repeat (2) @(negedge clk);
            `CHK({fault_status, alert_output}, 6'h03)
            fault_cond = 4'h0;
            host.wr(8'h02, 8'h0C);
            host.wr(8'h01, 8'h80);
            repeat (5) @(negedge clk);
            `CHK(output_enable_q, 1'b1)
            fault_cond = 4'h4;
            repeat (3) @(negedge clk);
            fault_cond = 4'h0;
            host.clr(1'b0);
            repeat (5) @(negedge clk);
            `CHK({latched_off_q, output_enable_q}, 2'b10)
            $display("clear test done");
        end
    endtask
    task summarize;
        begin
            $display("checks %0d errors %0d", samples_checked, error_cnt);
            if (error_cnt == 0 && samples_checked > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    initial begin
        rstn = 1'b0;
        enable_pin = 1'b0;
        vin_above_uvlo = 1'b0;
        strap_mode = 1'b0;
        strap_cmd_gate = 1'b1;
        strap_pin_control_gate = 1'b1;
        strap_hot_on_iin = 2'h1;
        input_current_warn_hit = 1'b0;
        address_select_pin = 4'hA;
        fault_cond = 4'h0;
        do_reset;
        t_regs;
        t_strap;
        t_onoff;
        t_margin;
        t_hot;
        t_clear;
        summarize;
    end
    // tests need about 320 cycles; allow a wide margin
    initial begin
        #40000;
        error_cnt++;
        summarize;
    end
endmodule

// *** verilog/pmoc_defines.vh ***
// constants for the output on/off command-register block
// assumes inclusion by bare name from the design files
`ifndef PMOC_DEFINES_VH
`define PMOC_DEFINES_VH

// ---------------------------------------------------------------
// command codes
// ---------------------------------------------------------------
`define PMOC_CMD_OPERATION 8'h01
`define PMOC_CMD_ONOFF_CFG 8'h02
`define PMOC_CMD_CLEAR_FAULTS 8'h03

// ---------------------------------------------------------------
// reset values and write masks
// ---------------------------------------------------------------
`define PMOC_OPER_RESET 8'h00
`define PMOC_ONOFF_RESET 8'h17
`define PMOC_ONOFF_FIXED 8'h13
`define PMOC_ONOFF_WR_MASK 8'h0C

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define PMOC_OPER_ON_BIT 7
`define PMOC_OPER_SOFT_BIT 6
`define PMOC_OPER_MARGIN_HI 5
`define PMOC_OPER_MARGIN_LO 2
`define PMOC_OPER_HOT_HI 1
`define PMOC_OPER_HOT_LO 0
`define PMOC_ONOFF_PU_BIT 4
`define PMOC_ONOFF_CMD_BIT 3
`define PMOC_ONOFF_CP_BIT 2
`define PMOC_ONOFF_PL_BIT 1
`define PMOC_ONOFF_SP_BIT 0

// ---------------------------------------------------------------
// field encodings
// ---------------------------------------------------------------
`define PMOC_MARGIN_LOW_IGN 4'h5
`define PMOC_MARGIN_LOW_ACT 4'h6
`define PMOC_MARGIN_HIGH_IGN 4'h9
`define PMOC_MARGIN_HIGH_ACT 4'hA
`define PMOC_HOT_ON_CODE 2'h1

// ---------------------------------------------------------------
// timing counts
// ---------------------------------------------------------------
`define PMOC_PU_SETTLE 2'h3

`endif

// *** verilog/pmoc_fault_latch.v ***
// sticky fault status bits with clear command and alert level
// assumes condition inputs come from logic on the same clock
`timescale 1ns/1ps
module pmoc_fault_latch #(
    parameter WIDTH = 4
) (
    // clock and reset
    input wire clk,
    input wire rstn,
    // condition levels and clear strobe
    input wire [WIDTH-1:0] cond,
    input wire clear,
    // status and alert
    output reg [WIDTH-1:0] status_q,
    output wire alert
);

reg [WIDTH-1:0] cond_q;
wire [WIDTH-1:0] cond_rise;
reg [WIDTH-1:0] status_d;

assign cond_rise = cond & ~cond_q;

// ---------------------------------------------------------------
// status update
// ---------------------------------------------------------------
// a fresh rising condition in the clear cycle survives the clear;
// a standing condition is set again one cycle later, so the alert
// drops for one cycle and then re-announces the fault
always @* begin
    if (clear) begin
        status_d = cond_rise;
    end else begin
        status_d = status_q | cond;
    end
end

always @(posedge clk) begin
    if (!rstn) begin
        status_q <= {WIDTH{1'b0}};
        cond_q <= {WIDTH{1'b0}};
    end else begin
        status_q <= status_d;
        cond_q <= cond;
    end
end

assign alert = |status_q;

endmodule

// *** verilog/pmoc_onoff_ctrl.v ***
// output on/off command registers, margin select, hot alarm, faults
// assumes a decoded command port from the bus framer on clk;
// pins and straps are asynchronous and are synchronised here
//
// Contract
// - address from four-bit select pin, sixteen choices
// - straps give defaults; host overwrites after power-up
// - on request needs bus-command gate set
// - enable needs vin ok, gate, pin rule
// - soft-off bit always reads zero
// - margin field decodes off, low, high
// - margin low/high loads matching target level
// - hot code 01 raises alarm on warning
// - power-up action bit always reads one
// - bus-command gate, reset zero, gates request
// - pin gate, reset one, selects pin use
// - polarity reads one, pin active high
// - shutdown rate reads one, immediate off
// - clear-faults clears status, drops alert
// - clear-faults never restarts latched-off unit
// - standing fault sets again, alerts again
`timescale 1ns/1ps
`include "pmoc_defines.vh"
module pmoc_onoff_ctrl #(
    parameter FAULT_W = 4,
    parameter [FAULT_W-1:0] LATCH_MASK = 4'hF,
    parameter [6:0] ADDR_BASE = 7'h50,
    parameter LEVEL_W = 8
) (
    // clock and reset
    input wire clk,
    input wire rstn,
    // pins and straps
    input wire [3:0] address_select_pin,
    input wire enable_pin,
    input wire vin_above_uvlo,
    input wire strap_mode,
    input wire strap_cmd_gate,
    input wire strap_pin_control_gate,
    input wire [1:0] strap_hot_on_iin,
    // decoded command port
    input wire cmd_valid,
    input wire cmd_write,
    input wire cmd_has_data,
    input wire [7:0] cmd_code,
    input wire [7:0] cmd_wdata,
    output reg rsp_valid_q,
    output reg [7:0] rsp_rdata_q,
    output reg cmd_reject_q,
    // fault and warning conditions
    input wire [FAULT_W-1:0] fault_cond,
    input wire input_current_warn_hit,
    // output levels
    input wire [LEVEL_W-1:0] vout_nominal,
    input wire [LEVEL_W-1:0] margin_low_level,
    input wire [LEVEL_W-1:0] margin_high_level,
    // block outputs
    output reg [6:0] slave_addr_q,
    output reg power_up_done_q,
    output reg output_enable_q,
    output reg latched_off_q,
    output reg [LEVEL_W-1:0] vout_target_q,
    output reg margin_act_on_fault_q,
    output reg regulator_hot_alarm_q,
    output wire [FAULT_W:0] fault_status,
    output wire alert_output
);

// ---------------------------------------------------------------
// pin synchroniser
// ---------------------------------------------------------------
localparam SYNC_W = 11;

reg [SYNC_W-1:0] sync1_q;
reg [SYNC_W-1:0] sync2_q;

always @(posedge clk) begin
    if (!rstn) begin
        sync1_q <= {SYNC_W{1'b0}};
        sync2_q <= {SYNC_W{1'b0}};
    end else begin
        sync1_q <= {address_select_pin, enable_pin, vin_above_uvlo, strap_mode,
                    strap_cmd_gate, strap_pin_control_gate, strap_hot_on_iin};
        sync2_q <= sync1_q;
    end
end

wire [3:0] addr_pin_s;
wire en_pin_s;
wire vin_ok_s;
wire strap_mode_s;
wire strap_cmd_s;
wire strap_cp_s;
wire [1:0] strap_hot_s;

assign addr_pin_s = sync2_q[10:7];
assign en_pin_s = sync2_q[6];
assign vin_ok_s = sync2_q[5];
assign strap_mode_s = sync2_q[4];
assign strap_cmd_s = sync2_q[3];
assign strap_cp_s = sync2_q[2];
assign strap_hot_s = sync2_q[1:0];

// ---------------------------------------------------------------
// functions
// ---------------------------------------------------------------
// margin decode: 2'd0 off, 2'd1 low, 2'd2 high; unlisted codes stay off
function [1:0] margin_kind;
    input [3:0] code;
    begin
        case (code)
            `PMOC_MARGIN_LOW_IGN, `PMOC_MARGIN_LOW_ACT: margin_kind = 2'h1;
            `PMOC_MARGIN_HIGH_IGN, `PMOC_MARGIN_HIGH_ACT: margin_kind = 2'h2;
            default: margin_kind = 2'h0;
        endcase
    end
endfunction

function margin_acts;
    input [3:0] code;
    begin
        margin_acts = (code == `PMOC_MARGIN_LOW_ACT) ||
                      (code == `PMOC_MARGIN_HIGH_ACT);
    end
endfunction

// ---------------------------------------------------------------
// power-up sequence
// ---------------------------------------------------------------
// wait for the synchroniser to fill before straps are trusted
localparam PU_WAIT = 1'b0;
localparam PU_DONE = 1'b1;

reg pu_state_q;
reg [1:0] pu_cnt_q;
wire pu_capture;

assign pu_capture = (pu_state_q == PU_WAIT) && (pu_cnt_q == `PMOC_PU_SETTLE);

always @(posedge clk) begin
    if (!rstn) begin
        pu_state_q <= PU_WAIT;
        pu_cnt_q <= 2'h0;
        power_up_done_q <= 1'b0;
        slave_addr_q <= 7'h00;
    end else begin
        case (pu_state_q)
            PU_WAIT: begin
                pu_cnt_q <= pu_cnt_q + 2'h1;
                if (pu_capture) begin
                    pu_state_q <= PU_DONE;
                    power_up_done_q <= 1'b1;
                    slave_addr_q <= {ADDR_BASE[6:4], addr_pin_s};
                end
            end
            PU_DONE: begin
                pu_cnt_q <= pu_cnt_q;
            end
            default: begin
                pu_state_q <= PU_WAIT;
            end
        endcase
    end
end

// ---------------------------------------------------------------
// command decode
// ---------------------------------------------------------------
wire is_oper;
wire is_onoff;
wire is_clear;
wire wr_ok;
wire wr_oper;
wire wr_onoff;
wire clear_faults;
wire rd_req;
wire bad_cmd;

assign is_oper = (cmd_code == `PMOC_CMD_OPERATION);
assign is_onoff = (cmd_code == `PMOC_CMD_ONOFF_CFG);
assign is_clear = (cmd_code == `PMOC_CMD_CLEAR_FAULTS);
// writes before power-up would fight the strap capture
assign wr_ok = cmd_valid && cmd_write && cmd_has_data && power_up_done_q;
assign wr_oper = wr_ok && is_oper;
assign wr_onoff = wr_ok && is_onoff;
// clear-faults is a bare command; a data byte makes it invalid
assign clear_faults = cmd_valid && cmd_write && !cmd_has_data && is_clear;
assign rd_req = cmd_valid && !cmd_write && (is_oper || is_onoff);
assign bad_cmd = cmd_valid && !clear_faults && !rd_req && !wr_oper && !wr_onoff;

// ---------------------------------------------------------------
// operation and on/off configuration registers
// ---------------------------------------------------------------
reg on_req_q;
reg [3:0] margin_q;
reg [1:0] hot_q;
reg cmd_gate_q;
reg pin_gate_q;
wire [7:0] oper_view;
wire [7:0] onoff_view;
wire [7:0] oper_reset_img;
wire [7:0] onoff_reset_img;
wire [7:0] onoff_wdata;

// reset images sliced per field so each register gets exactly its bits
assign oper_reset_img = `PMOC_OPER_RESET;
assign onoff_reset_img = `PMOC_ONOFF_RESET;
// fixed bits are masked off before they can reach a register
assign onoff_wdata = cmd_wdata & `PMOC_ONOFF_WR_MASK;

always @(posedge clk) begin
    if (!rstn) begin
        on_req_q <= oper_reset_img[`PMOC_OPER_ON_BIT];
        margin_q <= oper_reset_img[`PMOC_OPER_MARGIN_HI:`PMOC_OPER_MARGIN_LO];
        hot_q <= oper_reset_img[`PMOC_OPER_HOT_HI:`PMOC_OPER_HOT_LO];
        cmd_gate_q <= onoff_reset_img[`PMOC_ONOFF_CMD_BIT];
        pin_gate_q <= onoff_reset_img[`PMOC_ONOFF_CP_BIT];
    end else if (pu_capture && strap_mode_s) begin
        cmd_gate_q <= strap_cmd_s;
        pin_gate_q <= strap_cp_s;
        hot_q <= strap_hot_s;
    end else begin
        if (wr_oper) begin
            on_req_q <= cmd_wdata[`PMOC_OPER_ON_BIT];
            margin_q <= cmd_wdata[`PMOC_OPER_MARGIN_HI:`PMOC_OPER_MARGIN_LO];
            hot_q <= cmd_wdata[`PMOC_OPER_HOT_HI:`PMOC_OPER_HOT_LO];
        end
        if (wr_onoff) begin
            // only the two gate bits take host data
            cmd_gate_q <= onoff_wdata[`PMOC_ONOFF_CMD_BIT];
            pin_gate_q <= onoff_wdata[`PMOC_ONOFF_CP_BIT];
        end
    end
end

// read images built bit by bit; fixed bits are plain constants
assign oper_view[`PMOC_OPER_ON_BIT] = on_req_q;
assign oper_view[`PMOC_OPER_SOFT_BIT] = 1'b0;
assign oper_view[`PMOC_OPER_MARGIN_HI:`PMOC_OPER_MARGIN_LO] = margin_q;
assign oper_view[`PMOC_OPER_HOT_HI:`PMOC_OPER_HOT_LO] = hot_q;

assign onoff_view[7:5] = 3'h0;
assign onoff_view[`PMOC_ONOFF_PU_BIT] = 1'b1;
assign onoff_view[`PMOC_ONOFF_CMD_BIT] = cmd_gate_q;
assign onoff_view[`PMOC_ONOFF_CP_BIT] = pin_gate_q;
assign onoff_view[`PMOC_ONOFF_PL_BIT] = 1'b1;
assign onoff_view[`PMOC_ONOFF_SP_BIT] = 1'b1;

// ---------------------------------------------------------------
// command answers
// ---------------------------------------------------------------
always @(posedge clk) begin
    if (!rstn) begin
        rsp_valid_q <= 1'b0;
        rsp_rdata_q <= 8'h00;
        cmd_reject_q <= 1'b0;
    end else begin
        rsp_valid_q <= rd_req;
        // a refused command only pulses the reject flag
        cmd_reject_q <= bad_cmd;
        if (rd_req) begin
            rsp_rdata_q <= is_oper ? oper_view : onoff_view;
        end
    end
end

// ---------------------------------------------------------------
// fault status and alert
// ---------------------------------------------------------------
pmoc_fault_latch #(
    .WIDTH(FAULT_W + 1)
) u_faults (
    .clk(clk),
    .rstn(rstn),
    .cond({input_current_warn_hit, fault_cond}),
    .clear(clear_faults),
    .status_q(fault_status),
    .alert(alert_output)
);

// ---------------------------------------------------------------
// output enable and latch-off
// ---------------------------------------------------------------
wire bus_on;
wire pin_ok;
wire enable_req;
wire latch_hit;

assign bus_on = on_req_q && cmd_gate_q;
// pin is active high; a clear pin gate leaves the pin unread
assign pin_ok = !pin_gate_q || en_pin_s;
assign enable_req = bus_on && vin_ok_s && pin_ok && power_up_done_q;
assign latch_hit = |(fault_cond & LATCH_MASK);

always @(posedge clk) begin
    if (!rstn) begin
        latched_off_q <= 1'b0;
        output_enable_q <= 1'b0;
    end else begin
        // only dropping the request releases the latch, never a clear
        if (latch_hit && output_enable_q) begin
            latched_off_q <= 1'b1;
        end else if (!enable_req) begin
            latched_off_q <= 1'b0;
        end
        // off takes effect on the next edge, no ramp down
        output_enable_q <= enable_req && !latched_off_q && !latch_hit;
    end
end

// ---------------------------------------------------------------
// margin target
// ---------------------------------------------------------------
always @(posedge clk) begin
    if (!rstn) begin
        vout_target_q <= {LEVEL_W{1'b0}};
        margin_act_on_fault_q <= 1'b0;
    end else begin
        case (margin_kind(margin_q))
            2'h1: vout_target_q <= margin_low_level;
            2'h2: vout_target_q <= margin_high_level;
            default: vout_target_q <= vout_nominal;
        endcase
        margin_act_on_fault_q <= margin_acts(margin_q);
    end
end

// ---------------------------------------------------------------
// hot alarm
// ---------------------------------------------------------------
wire hot_armed;

assign hot_armed = (hot_q == `PMOC_HOT_ON_CODE);

always @(posedge clk) begin
    if (!rstn) begin
        regulator_hot_alarm_q <= 1'b0;
    end else begin
        regulator_hot_alarm_q <= input_current_warn_hit && hot_armed;
    end
end

endmodule
